// [calendar_rtc_cfg.svh]
`ifndef CALENDAR_RTC_CFG_SVH
`define CALENDAR_RTC_CFG_SVH
// ****************************************
// Timing figures
// ****************************************
`define CAL_OSC_HZ 32768
`define CAL_FIRST_DIV 256
`define CAL_SECOND_DIV 128
`define CAL_FIRST_W 8
`define CAL_SECOND_W 7
`define CAL_FIRST_LAST 8'hFF
`define CAL_SECOND_LAST 7'h7F
// Keep-out spans 128 oscillator cycles, half either side of the update
`define CAL_KEEPOUT_OSC 128
`define CAL_KEEPOUT_LATE 8'hC0
`define CAL_KEEPOUT_EARLY 8'h40
// ****************************************
// Field limits and reset values
// ****************************************
`define CAL_SEC_MAX 8'h3B
`define CAL_MIN_MAX 8'h3B
`define CAL_HOUR_MAX 8'h17
`define CAL_DOW_MAX 8'h06
`define CAL_MON_MAX 8'h0C
`define CAL_FEB 8'h02
`define CAL_DAY_FIRST 8'h01
`define CAL_MON_FIRST 8'h01
`define CAL_YEAR_W 12
`define CAL_YEAR_RESET 12'h000
`endif

// [calendar_rtc_pkg.sv]
package calendar_rtc_pkg;
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] mon;
    logic [7:0] day;
    logic [7:0] dow;
    logic [7:0] hour;
    logic [7:0] min;
    logic [7:0] sec;
  } calendar_type;
endpackage : calendar_rtc_pkg

// [calendar_rtc_prescaler.sv]
`timescale 1ns/100ps
`include "calendar_rtc_cfg.svh"
module calendar_rtc_prescaler import calendar_rtc_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic lowFreqOsc,
  input wire logic bcdFormatSelect,
  input wire logic countingHold,
  input wire logic calWrite,
  input wire calendar_type calLoad,
  output calendar_type calendarOut,
  output logic calendarReadSafe
);

  // ****************************************
  // Conversion functions
  // ****************************************
  function automatic logic [7:0] toBcd8(input logic [7:0] v);
    logic [7:0] t;
    t = v / 8'h0A;
    return {t[3:0], 4'(v % 8'h0A)};
  endfunction : toBcd8

  function automatic logic [7:0] fromBcd8(input logic [7:0] v);
    return {4'h0, v[7:4]} * 8'h0A + {4'h0, v[3:0]};
  endfunction : fromBcd8

  function automatic logic [15:0] toBcd16(input logic [11:0] v);
    return {4'(v / 12'h3E8), 4'((v / 12'h064) % 12'h00A), 4'((v / 12'h00A) % 12'h00A), 4'(v % 12'h00A)};
  endfunction : toBcd16

  function automatic logic [11:0] fromBcd16(input logic [15:0] v);
    return 12'(v[15:12] * 14'h3E8 + v[11:8] * 14'h064 + v[7:4] * 14'h00A + v[3:0]);
  endfunction : fromBcd16

  function automatic logic [7:0] monthDays(input logic [7:0] m, input logic leap);
    case (m)
      8'h02: monthDays = leap ? 8'h1D : 8'h1C;
      8'h04, 8'h06, 8'h09, 8'h0B: monthDays = 8'h1E;
      default: monthDays = 8'h1F;
    endcase
  endfunction : monthDays

  // ****************************************
  // Oscillator synchroniser
  // ****************************************
  logic oscMeta_r, oscSync_r, oscPrev_r;
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      oscMeta_r <= 1'b0;
      oscSync_r <= 1'b0;
      oscPrev_r <= 1'b0;
    end else begin
      oscMeta_r <= lowFreqOsc;
      oscSync_r <= oscMeta_r;
      oscPrev_r <= oscSync_r;
    end
  end
  wire oscTick = oscSync_r & ~oscPrev_r;

  // ****************************************
  // Prescalers
  // ****************************************
  logic [`CAL_FIRST_W-1:0] firstPrescaler_r, firstPrescaler_nxt;
  logic [`CAL_SECOND_W-1:0] secondPrescaler_r, secondPrescaler_nxt;
  // hold and write both gate all counting; no low-power input gates counting; no counter mode path
  wire running = ~countingHold & ~calWrite;
  wire advance = running & oscTick;
  // divide-by-256 output clocks second prescaler; fixed divisors
  wire firstCarry = advance & (firstPrescaler_r == `CAL_FIRST_LAST);
  // divide-by-128 output gives the second tick
  wire secTick = firstCarry & (secondPrescaler_r == `CAL_SECOND_LAST);
  assign firstPrescaler_nxt = calWrite ? '0 : (advance ? firstPrescaler_r + 1'b1 : firstPrescaler_r);
  assign secondPrescaler_nxt = calWrite ? '0 : (firstCarry ? secondPrescaler_r + 1'b1 : secondPrescaler_r);

  // ****************************************
  // Calendar counters
  // ****************************************
  logic [7:0] sec_r, min_r, hour_r, dow_r, day_r, mon_r;
  logic [7:0] sec_nxt, min_nxt, hour_nxt, dow_nxt, day_nxt, mon_nxt;
  logic [`CAL_YEAR_W-1:0] year_r, year_nxt;
  wire leapYear = (year_r[1:0] == 2'b00);
  wire secWrap = secTick & (sec_r == `CAL_SEC_MAX);
  wire minWrap = secWrap & (min_r == `CAL_MIN_MAX);
  wire hourWrap = minWrap & (hour_r == `CAL_HOUR_MAX);
  wire dayWrap = hourWrap & (day_r == monthDays(mon_r, leapYear));
  wire monWrap = dayWrap & (mon_r == `CAL_MON_MAX);
  // writes arrive in the selected format
  wire [7:0] ldSec = bcdFormatSelect ? fromBcd8(calLoad.sec) : calLoad.sec;
  wire [7:0] ldMin = bcdFormatSelect ? fromBcd8(calLoad.min) : calLoad.min;
  wire [7:0] ldHour = bcdFormatSelect ? fromBcd8(calLoad.hour) : calLoad.hour;
  wire [7:0] ldDay = bcdFormatSelect ? fromBcd8(calLoad.day) : calLoad.day;
  wire [7:0] ldMon = bcdFormatSelect ? fromBcd8(calLoad.mon) : calLoad.mon;
  wire [`CAL_YEAR_W-1:0] ldYear = bcdFormatSelect ? fromBcd16(calLoad.year) : calLoad.year[`CAL_YEAR_W-1:0];
  // write takes effect at once; fields advance together
  assign sec_nxt = calWrite ? ldSec : (secWrap ? 8'h00 : (secTick ? sec_r + 8'h01 : sec_r));
  assign min_nxt = calWrite ? ldMin : (minWrap ? 8'h00 : (secWrap ? min_r + 8'h01 : min_r));
  assign hour_nxt = calWrite ? ldHour : (hourWrap ? 8'h00 : (minWrap ? hour_r + 8'h01 : hour_r));
  assign dow_nxt = calWrite ? calLoad.dow : (hourWrap ? ((dow_r == `CAL_DOW_MAX) ? 8'h00 : dow_r + 8'h01) : dow_r);
  assign day_nxt = calWrite ? ldDay : (dayWrap ? `CAL_DAY_FIRST : (hourWrap ? day_r + 8'h01 : day_r));
  assign mon_nxt = calWrite ? ldMon : (monWrap ? `CAL_MON_FIRST : (dayWrap ? mon_r + 8'h01 : mon_r));
  assign year_nxt = calWrite ? ldYear : (monWrap ? year_r + 1'b1 : year_r);

  wire keepOut = ((secondPrescaler_r == `CAL_SECOND_LAST) && (firstPrescaler_r >= `CAL_KEEPOUT_LATE)) ||
                 ((secondPrescaler_r == '0) && (firstPrescaler_r < `CAL_KEEPOUT_EARLY));

  // presentation follows the live format select
  calendar_type present;
  assign present.sec = bcdFormatSelect ? toBcd8(sec_r) : sec_r;
  assign present.min = bcdFormatSelect ? toBcd8(min_r) : min_r;
  assign present.hour = bcdFormatSelect ? toBcd8(hour_r) : hour_r;
  assign present.dow = dow_r;
  assign present.day = bcdFormatSelect ? toBcd8(day_r) : day_r;
  assign present.mon = bcdFormatSelect ? toBcd8(mon_r) : mon_r;
  assign present.year = bcdFormatSelect ? toBcd16(year_r) : {4'h0, year_r};

  calendar_type calendarOut_r;
  logic calendarReadSafe_r;

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      firstPrescaler_r <= '0;
      secondPrescaler_r <= '0;
      sec_r <= 8'h00;
      min_r <= 8'h00;
      hour_r <= 8'h00;
      dow_r <= 8'h00;
      day_r <= `CAL_DAY_FIRST;
      mon_r <= `CAL_MON_FIRST;
      year_r <= `CAL_YEAR_RESET;
      calendarOut_r <= '0;
      calendarReadSafe_r <= 1'b0;
    end else begin
      firstPrescaler_r <= firstPrescaler_nxt;
      secondPrescaler_r <= secondPrescaler_nxt;
      sec_r <= sec_nxt;
      min_r <= min_nxt;
      hour_r <= hour_nxt;
      dow_r <= dow_nxt;
      day_r <= day_nxt;
      mon_r <= mon_nxt;
      year_r <= year_nxt;
      calendarOut_r <= present;
      calendarReadSafe_r <= ~keepOut;
    end
  end
  assign calendarOut = calendarOut_r;
  assign calendarReadSafe = calendarReadSafe_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_sec_tick_origin: assert property (secTick |-> firstPrescaler_r == 8'hFF && secondPrescaler_r == 7'h7F)
    else $error("second tick not at prescaler end");
  a_first_to_second: assert property (firstCarry |=> secondPrescaler_r == 7'($past(secondPrescaler_r) + 7'h01))
    else $error("second prescaler missed a step");
  a_sec_wrap: assert property (secWrap |=> sec_r == 8'h00 && min_r != $past(min_r))
    else $error("seconds did not wrap and carry");
  a_minute_step: assert property (secTick && sec_r == 8'h3B && min_r < 8'h3B |=> min_r == $past(min_r) + 8'h01)
    else $error("minute not advanced");
  a_hold_freeze: assert property (countingHold && !calWrite |=> $stable(firstPrescaler_r) && $stable(sec_r))
    else $error("hold did not freeze counting");
  a_write_clears: assert property (calWrite |=> firstPrescaler_r == 8'h00 && secondPrescaler_r == 7'h00)
    else $error("write did not clear prescalers");
  a_leap_feb: assert property (hourWrap && mon_r == 8'h02 && day_r == 8'h1C && year_r[1:0] == 2'b00 |=> day_r == 8'h1D)
    else $error("leap February skipped day 29");
  a_ready_drop: assert property (secTick |=> !calendarReadSafe_r)
    else $error("read-safe flag high after update");
  a_ready_enter: assert property (advance && secondPrescaler_r == `CAL_SECOND_LAST && firstPrescaler_r == 8'hBF
    |-> ##2 !calendarReadSafe_r)
    else $error("read-safe flag high before update");
  a_ready_exit: assert property (secondPrescaler_r == 7'h00 && firstPrescaler_r == `CAL_KEEPOUT_EARLY
    |=> calendarReadSafe_r)
    else $error("read-safe flag low after window");
  a_bcd_present: assert property (bcdFormatSelect |=> calendarOut_r.sec == toBcd8($past(sec_r)))
    else $error("BCD seconds wrong");
  a_format_live: assert property ($changed(bcdFormatSelect) && oscTick && !countingHold && !calWrite |=> firstPrescaler_r != $past(firstPrescaler_r))
    else $error("format change stopped counting");
  a_dow_wrap: assert property (hourWrap && dow_r == `CAL_DOW_MAX |=> dow_r == 8'h00)
    else $error("day of week did not wrap");
  a_day_first: assert property (dayWrap |=> day_r == `CAL_DAY_FIRST)
    else $error("day of month did not restart");
  a_year_step: assert property (monWrap |=> year_r == $past(year_r) + 12'h001)
    else $error("year not advanced");
  a_binary_present: assert property (!bcdFormatSelect |=> calendarOut_r.sec == $past(sec_r))
    else $error("binary seconds wrong");
  a_write_load: assert property (calWrite && !bcdFormatSelect |=> sec_r == $past(calLoad.sec))
    else $error("write did not load at once");

  c_second_tick: cover property (secTick);
  c_day_roll: cover property (dayWrap);
  c_write_live: cover property (calWrite ##1 secTick);
  c_hold_release: cover property (countingHold ##1 !countingHold);
  c_leap_day: cover property (hourWrap && leapYear && mon_r == `CAL_FEB);

endmodule : calendar_rtc_prescaler

// [low_freq_osc_model.sv]
`timescale 1ns/100ps
module low_freq_osc_model (
  output logic oscOut
);
  // ****************************************
  // Free-running oscillator, scaled period
  // ****************************************
  // scaled oscillator source, 10 ns period
  initial oscOut = 1'b0;
  always #5 oscOut = ~oscOut;
endmodule : low_freq_osc_model

// [test_calendar_rtc_prescaler.sv]
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin checked++; if ((got) !== (exp)) begin nMismatch++; \
  $display("CHECK FAILED %s exp %h got %h", nm, exp, got); end end
module test_calendar_rtc_prescaler import calendar_rtc_pkg::*;;
  // ****************************************
  // Clock, reset and instances
  // ****************************************
  logic sysClk = 1'b0;
  logic resetN = 1'b0;
  logic oscLine;
  logic bcdFormatSelect = 1'b0;
  logic countingHold = 1'b0;
  logic calWrite = 1'b0;
  calendar_type calLoad = '0;
  calendar_type calendarOut;
  logic calendarReadSafe;
  int nMismatch = 0;
  int checked = 0;
  always #2.5 sysClk = ~sysClk;
  low_freq_osc_model osc_u (.oscOut(oscLine));
  calendar_rtc_prescaler dut_u (.sys_clk(sysClk), .reset_n(resetN), .lowFreqOsc(oscLine),
    .bcdFormatSelect(bcdFormatSelect), .countingHold(countingHold), .calWrite(calWrite),
    .calLoad(calLoad), .calendarOut(calendarOut), .calendarReadSafe(calendarReadSafe));
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checked, nMismatch);
    if (nMismatch == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish
  task automatic load_cal(input logic bcd, input calendar_type v);
    @(negedge sysClk);
    bcdFormatSelect = bcd;
    calLoad = v;
    calWrite = 1'b1;
    @(negedge sysClk);
    calWrite = 1'b0;
    repeat (2) @(negedge sysClk);
  endtask : load_cal
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset_values;
    `CHK("out in reset", 64'h0, calendarOut)
    `CHK("safe in reset", 1'b0, calendarReadSafe)
    resetN = 1'b1;
    @(negedge sysClk);
    `CHK("out after reset", {16'h0000, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00}, calendarOut)
    `CHK("safe after reset", 1'b0, calendarReadSafe)
  endtask : test_reset_values
  task automatic test_binary_load;
    calendar_type v;
    v = {16'h07E7, 8'h0C, 8'h1F, 8'h03, 8'h17, 8'h3B, 8'h3B};
    load_cal(1'b0, v);
    `CHK("binary load", v, calendarOut)
  endtask : test_binary_load
  task automatic test_leap_tick_hold;
    calendar_type v;
    int n;
    v = {16'h2024, 8'h02, 8'h28, 8'h06, 8'h23, 8'h59, 8'h59};
    load_cal(1'b1, v);
    `CHK("bcd load", v, calendarOut)
    repeat (3000) @(negedge sysClk);
    countingHold = 1'b1;
    repeat (3000) @(negedge sysClk);
    `CHK("held value", v, calendarOut)
    countingHold = 1'b0;
    n = 0;
    while (calendarOut === v && n < 70000) begin
      @(negedge sysClk);
      n++;
    end
    `CHK("second length", 1'b1, (n >= 62520 && n <= 62550))
    `CHK("leap rollover", {16'h2024, 8'h02, 8'h29, 8'h00, 8'h00, 8'h00, 8'h00}, calendarOut)
    `CHK("keep-out at update", 1'b0, calendarReadSafe)
    bcdFormatSelect = 1'b0;
    repeat (2) @(negedge sysClk);
    `CHK("binary after switch", {16'h07E8, 8'h02, 8'h1D, 8'h00, 8'h00, 8'h00, 8'h00}, calendarOut)
    repeat (300) @(negedge sysClk);
    `CHK("read safe after window", 1'b1, calendarReadSafe)
  endtask : test_leap_tick_hold
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(negedge sysClk);
    test_reset_values;
    test_binary_load;
    test_leap_tick_hold;
    tally_and_finish;
  end
  initial begin
    repeat (80000) @(posedge sysClk);
    nMismatch++;
    tally_and_finish;
  end
endmodule : test_calendar_rtc_prescaler
